/* File: inc/flcs_map.vh */
// register map, command codes and timing (clock rate and pin phase times) of the flash command controller
`ifndef FLCS_MAP_VH
`define FLCS_MAP_VH
// register offsets (byte addresses)
`define FLCS_REG_CMD 8'h00
`define FLCS_REG_ADDR 8'h04
`define FLCS_REG_WDATA 8'h08
`define FLCS_REG_STAT 8'h0c
`define FLCS_REG_RDATA 8'h10
`define FLCS_REG_ID 8'h14
`define FLCS_REG_CFG 8'h18
// order codes written to the command register
`define FLCS_OP_READ_ARRAY 4'h0
`define FLCS_OP_READ_ID 4'h1
`define FLCS_OP_READ_STATUS 4'h2
`define FLCS_OP_CLEAR_STATUS 4'h3
`define FLCS_OP_PROGRAM 4'h4
`define FLCS_OP_ERASE 4'h5
`define FLCS_OP_SUSPEND 4'h6
`define FLCS_OP_RESUME 4'h7
`define FLCS_OP_READ_DATA 4'h8
`define FLCS_OP_POLL 4'h9
`define FLCS_OP_RESET 4'ha
// device command codes
`define FLCS_DEV_READ_ARRAY 8'hff
`define FLCS_DEV_IDENT 8'h90
`define FLCS_DEV_READ_STATUS 8'h70
`define FLCS_DEV_CLEAR_STATUS 8'h50
`define FLCS_DEV_PROG_SETUP 8'h40
`define FLCS_DEV_ERASE_SETUP 8'h20
`define FLCS_DEV_CONFIRM 8'hd0
`define FLCS_DEV_SUSPEND 8'hb0
// status register fields
`define FLCS_SR_READY 7
`define FLCS_SR_SUSP 6
`define FLCS_SR_ERASE_ERR 5
`define FLCS_SR_PROG_ERR 4
`define FLCS_SR_SUPPLY_LOW 3
`define FLCS_SR_MASK 8'hf8
// status register of the controller
`define FLCS_ST_BUSY 8
`define FLCS_ST_REFUSED 9
`define FLCS_ST_ERASING 10
`define FLCS_ST_SUSPENDED 11
`define FLCS_ST_SEQ_ERR 12
// timing: clock rate and pin phase times
`define FLCS_CLK_MHZ 50
`define FLCS_T_SETUP_NS 40
`define FLCS_T_STROBE_NS 100
`define FLCS_T_HOLD_NS 40
`define FLCS_T_RP_NS 1000
`endif

/* File: rtl/flcs_bus_cycle.v */
// one strobed read or write cycle on the flash pins
`timescale 1ns/10ps
`default_nettype none
`include "flcs_map.vh"
module flcs_bus_cycle #(
   parameter AW = 18,
   parameter DW = 16
) (
   input wire ref_clk,
   input wire reset,
   input wire start,
   input wire wr,
   input wire [AW-1:0] addr_in,
   input wire [DW-1:0] wdata,
   output reg done_q,
   output reg [DW-1:0] rdata_q,
   output reg ce_n_q,
   output reg oe_n_q,
   output reg we_n_q,
   output reg [AW-1:0] addr_q,
   output reg [DW-1:0] dq_o_q,
   output reg dq_oe_q,
   input wire [DW-1:0] dq_i
);
   // least times round up to whole cycles
   localparam integer SETUP_CYC = (`FLCS_T_SETUP_NS * `FLCS_CLK_MHZ + 999) / 1000;
   localparam integer STROBE_CYC = (`FLCS_T_STROBE_NS * `FLCS_CLK_MHZ + 999) / 1000;
   localparam integer HOLD_CYC = (`FLCS_T_HOLD_NS * `FLCS_CLK_MHZ + 999) / 1000;
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_SETUP = 4'h2;
   localparam [3:0] S_STROBE = 4'h4;
   localparam [3:0] S_HOLD = 4'h8;
   reg [3:0] state_q; // phase of the cycle
   reg [7:0] cnt_q; // cycles left in the phase
   reg wr_q; // direction of the running cycle

   // chip select falls first so the strobe edge is always the last falling edge
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= S_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= {DW{1'b0}};
         ce_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
         addr_q <= {AW{1'b0}};
         dq_o_q <= {DW{1'b0}};
         dq_oe_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  state_q <= S_SETUP;
                  cnt_q <= SETUP_CYC[7:0];
                  wr_q <= wr;
                  ce_n_q <= 1'b0;
                  addr_q <= addr_in;
                  dq_o_q <= wdata;
                  dq_oe_q <= wr; // drive only on writes
               end
            end
            S_SETUP: begin
               if (cnt_q == 8'h01) begin
                  state_q <= S_STROBE;
                  cnt_q <= STROBE_CYC[7:0];
                  we_n_q <= ~wr_q;
                  oe_n_q <= wr_q; // status is captured by the device on this edge
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            S_STROBE: begin
               if (cnt_q == 8'h01) begin
                  state_q <= S_HOLD;
                  cnt_q <= HOLD_CYC[7:0];
                  we_n_q <= 1'b1;
                  oe_n_q <= 1'b1; // strobe rises so every poll toggles it
                  if (!wr_q)
                     rdata_q <= dq_i;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            S_HOLD: begin
               if (cnt_q == 8'h01) begin
                  state_q <= S_IDLE;
                  ce_n_q <= 1'b1;
                  dq_oe_q <= 1'b0;
                  done_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // flcs_bus_cycle
`default_nettype wire

/* File: rtl/flcs_host.v */
// host controller that drives the flash command decoder through its pins
`timescale 1ns/10ps
`default_nettype none
`include "flcs_map.vh"
module flcs_host #(
   parameter AW = 18,
   parameter DW = 16,
   parameter RP_CYC = (`FLCS_T_RP_NS * `FLCS_CLK_MHZ + 999) / 1000
) (
   input wire ref_clk,
   input wire reset,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_q,
   output wire flash_ce_n,
   output wire flash_oe_n,
   output wire flash_we_n,
   output reg flash_rp_n_q,
   output reg flash_byte_n_q,
   output wire [AW-1:0] flash_addr,
   output wire [DW-1:0] flash_dq_o,
   output wire flash_dq_oe,
   input wire [DW-1:0] flash_dq_i
);
   localparam [4:0] M_IDLE = 5'h01;
   localparam [4:0] M_ISSUE = 5'h02;
   localparam [4:0] M_WAIT = 5'h04;
   localparam [4:0] M_RESET = 5'h08;
   localparam [4:0] M_NEXT = 5'h10;
   localparam [1:0] A_END = 2'h0;
   localparam [1:0] A_WRITE = 2'h1;
   localparam [1:0] A_READ = 2'h2;
   localparam [1:0] A_POLL = 2'h3;

   reg [4:0] mode_q; // sequencer state
   reg [3:0] op_q; // order being run
   reg [1:0] step_q; // bus cycle index within the order
   reg [1:0] act_q; // kind of the cycle in flight
   reg [AW-1:0] addr_q; // target address from software
   reg [DW-1:0] wdata_q; // program word from software
   reg [DW-1:0] rdata_q; // last array word read
   reg [DW-1:0] id_mfr_q; // identifier value at address 0
   reg [DW-1:0] id_dev_q; // identifier value at address 1
   reg [7:0] status_q; // last status byte, reserved bits masked
   reg refused_q; // last order was refused
   reg erasing_q; // erase launched and not yet seen finished
   reg suspended_q; // erase suspend confirmed by the device
   reg prog_armed_q; // device left in program setup
   reg [15:0] rp_cnt_q; // reset pulse length counter
   reg [1:0] act; // kind of cycle for the current step
   reg [DW-1:0] act_data; // data for the current step
   reg [AW-1:0] act_addr; // address for the current step
   wire cyc_done; // bus cycle finished
   wire [DW-1:0] cyc_rdata; // data sampled by the bus cycle
   wire cyc_start; // launch a bus cycle
   wire busy; // order in progress
   wire [7:0] sr_now; // freshly read status, reserved bits dropped

   assign busy = (mode_q != M_IDLE);
   assign cyc_start = (mode_q == M_ISSUE) && (act != A_END);
   assign sr_now = cyc_rdata[7:0] & `FLCS_SR_MASK; // upper byte ignored

   // command word table: which cycle each step of an order performs
   always @* begin
      act = A_END;
      act_data = {DW{1'b0}};
      act_addr = {AW{1'b0}};
      case (op_q)
         `FLCS_OP_READ_ARRAY: begin
            act_data = {{(DW-8){1'b0}}, `FLCS_DEV_READ_ARRAY};
            if (step_q == 2'h0 || (step_q == 2'h1 && prog_armed_q))
               act = A_WRITE; // second FFH only out of program setup
         end
         `FLCS_OP_READ_ID: begin
            act_data = {{(DW-8){1'b0}}, `FLCS_DEV_IDENT};
            act_addr = {{(AW-1){1'b0}}, step_q == 2'h2}; // only A0 matters
            if (step_q == 2'h0)
               act = A_WRITE;
            else if (step_q != 2'h3)
               act = A_READ;
         end
         `FLCS_OP_READ_STATUS: begin
            act_data = {{(DW-8){1'b0}}, `FLCS_DEV_READ_STATUS};
            act = (step_q == 2'h0) ? A_WRITE : (step_q == 2'h1) ? A_READ : A_END;
         end
         `FLCS_OP_CLEAR_STATUS: begin
            act_data = {{(DW-8){1'b0}}, `FLCS_DEV_CLEAR_STATUS};
            act = (step_q == 2'h0) ? A_WRITE : A_END;
         end
         `FLCS_OP_PROGRAM: begin
            act_addr = addr_q;
            act_data = (step_q == 2'h0) ? {{(DW-8){1'b0}}, `FLCS_DEV_PROG_SETUP} : wdata_q;
            act = (step_q == 2'h2) ? A_POLL : (step_q == 2'h3) ? A_END : A_WRITE;
         end
         `FLCS_OP_ERASE: begin
            act_addr = addr_q;
            act_data = (step_q == 2'h0) ? {{(DW-8){1'b0}}, `FLCS_DEV_ERASE_SETUP} :
                                          {{(DW-8){1'b0}}, `FLCS_DEV_CONFIRM};
            act = (step_q < 2'h2) ? A_WRITE : A_END;
         end
         `FLCS_OP_SUSPEND: begin
            act_data = {{(DW-8){1'b0}}, `FLCS_DEV_SUSPEND};
            act = (step_q == 2'h0) ? A_WRITE : (step_q == 2'h1) ? A_POLL : A_END;
         end
         `FLCS_OP_RESUME: begin
            act_data = {{(DW-8){1'b0}}, `FLCS_DEV_CONFIRM};
            act = (step_q == 2'h0) ? A_WRITE : A_END;
         end
         `FLCS_OP_READ_DATA: begin
            act_addr = addr_q; // device must be in array mode first
            act = (step_q == 2'h0) ? A_READ : A_END;
         end
         `FLCS_OP_POLL: begin
            act = (step_q == 2'h0) ? A_POLL : A_END; // device shows status after launch
         end
         default: begin
            act = A_END;
         end
      endcase
   end

   // register port and order sequencer
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mode_q <= M_IDLE;
         op_q <= 4'h0;
         step_q <= 2'h0;
         act_q <= A_END;
         addr_q <= {AW{1'b0}};
         wdata_q <= {DW{1'b0}};
         rdata_q <= {DW{1'b0}};
         id_mfr_q <= {DW{1'b0}};
         id_dev_q <= {DW{1'b0}};
         status_q <= 8'h00;
         refused_q <= 1'b0;
         erasing_q <= 1'b0;
         suspended_q <= 1'b0;
         prog_armed_q <= 1'b0;
         rp_cnt_q <= 16'h0000;
         flash_rp_n_q <= 1'b1;
         flash_byte_n_q <= 1'b1;
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         // read data stand one cycle after the strobe, zero otherwise
         reg_rdata_q <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `FLCS_REG_ADDR: reg_rdata_q <= {{(32-AW){1'b0}}, addr_q};
               `FLCS_REG_WDATA: reg_rdata_q <= {{(32-DW){1'b0}}, wdata_q};
               `FLCS_REG_STAT: reg_rdata_q <= {19'h00000,
                  status_q[`FLCS_SR_PROG_ERR] & status_q[`FLCS_SR_ERASE_ERR],
                  suspended_q, erasing_q, refused_q, busy, status_q};
               `FLCS_REG_RDATA: reg_rdata_q <= {{(32-DW){1'b0}}, rdata_q};
               `FLCS_REG_ID: reg_rdata_q <= {id_dev_q[15:0], id_mfr_q[15:0]};
               `FLCS_REG_CFG: reg_rdata_q <= {31'h0000_0000, ~flash_byte_n_q};
               default: reg_rdata_q <= 32'h0000_0000;
            endcase
         end
         if (reg_wr && reg_addr == `FLCS_REG_ADDR)
            addr_q <= reg_wdata[AW-1:0];
         if (reg_wr && reg_addr == `FLCS_REG_WDATA)
            wdata_q <= reg_wdata[DW-1:0];
         if (reg_wr && reg_addr == `FLCS_REG_CFG && !busy)
            flash_byte_n_q <= ~reg_wdata[0];
         case (mode_q)
            M_IDLE: begin
               // orders arriving while busy are dropped; software polls busy first
               if (reg_wr && reg_addr == `FLCS_REG_CMD) begin
                  op_q <= reg_wdata[3:0];
                  step_q <= 2'h0;
                  refused_q <= 1'b0;
                  if (reg_wdata[3:0] == `FLCS_OP_ERASE &&
                      (status_q[`FLCS_SR_SUPPLY_LOW] || erasing_q))
                     refused_q <= 1'b1; // low supply must be cleared first
                  else if (reg_wdata[3:0] == `FLCS_OP_SUSPEND && (!erasing_q || suspended_q))
                     refused_q <= 1'b1; // suspend only has meaning mid-erase
                  else if (reg_wdata[3:0] == `FLCS_OP_RESUME && !suspended_q)
                     refused_q <= 1'b1; // resume without suspend does nothing
                  else if (suspended_q && reg_wdata[3:0] != `FLCS_OP_READ_ARRAY &&
                           reg_wdata[3:0] != `FLCS_OP_READ_STATUS &&
                           reg_wdata[3:0] != `FLCS_OP_READ_DATA &&
                           reg_wdata[3:0] != `FLCS_OP_RESUME &&
                           reg_wdata[3:0] != `FLCS_OP_RESET)
                     refused_q <= 1'b1; // suspended device takes few commands
                  else if (erasing_q && !suspended_q && reg_wdata[3:0] != `FLCS_OP_READ_STATUS &&
                           reg_wdata[3:0] != `FLCS_OP_POLL && reg_wdata[3:0] != `FLCS_OP_SUSPEND &&
                           reg_wdata[3:0] != `FLCS_OP_RESET)
                     refused_q <= 1'b1; // running erase takes status, poll, suspend and reset only
                  else if (reg_wdata[3:0] == `FLCS_OP_RESET) begin
                     mode_q <= M_RESET;
                     rp_cnt_q <= RP_CYC[15:0];
                     flash_rp_n_q <= 1'b0; // pin stops the machine at once
                  end else
                     mode_q <= M_ISSUE;
               end
            end
            M_ISSUE: begin
               act_q <= act;
               if (act == A_END)
                  mode_q <= M_IDLE;
               else
                  mode_q <= M_WAIT;
            end
            M_WAIT: begin
               if (cyc_done) begin
                  mode_q <= M_NEXT;
                  if (act_q == A_WRITE) begin
                     // remember whether the last write left program setup armed
                     prog_armed_q <= (op_q == `FLCS_OP_PROGRAM) && (step_q == 2'h0);
                     if (op_q == `FLCS_OP_ERASE && step_q == 2'h1)
                        erasing_q <= 1'b1;
                     if (op_q == `FLCS_OP_RESUME)
                        suspended_q <= 1'b0; // device drops ready and suspend bits
                  end else if (op_q == `FLCS_OP_READ_ID) begin
                     if (step_q == 2'h1)
                        id_mfr_q <= cyc_rdata;
                     else
                        id_dev_q <= cyc_rdata;
                  end else if (op_q == `FLCS_OP_READ_DATA) begin
                     rdata_q <= cyc_rdata;
                  end else begin
                     status_q <= sr_now;
                     if (sr_now[`FLCS_SR_READY]) begin
                        // suspend and erase flags are taken only once ready is seen
                        suspended_q <= sr_now[`FLCS_SR_SUSP];
                        if (!sr_now[`FLCS_SR_SUSP])
                           erasing_q <= 1'b0;
                     end else if (act_q == A_POLL)
                        mode_q <= M_ISSUE; // busy: poll again with a fresh strobe
                  end
               end
            end
            M_NEXT: begin
               step_q <= step_q + 2'h1;
               mode_q <= M_ISSUE;
            end
            M_RESET: begin
               if (rp_cnt_q == 16'h0001) begin
                  flash_rp_n_q <= 1'b1;
                  mode_q <= M_IDLE;
                  erasing_q <= 1'b0;
                  suspended_q <= 1'b0;
                  prog_armed_q <= 1'b0;
               end else
                  rp_cnt_q <= rp_cnt_q - 16'h0001;
            end
            default: begin
               mode_q <= M_IDLE;
            end
         endcase
      end
   end

   // pin cycle engine, shared by every step
   flcs_bus_cycle #(
      .AW(AW),
      .DW(DW)
   ) flcs_bus_cycle_inst (
      .ref_clk(ref_clk),
      .reset(reset),
      .start(cyc_start),
      .wr(act == A_WRITE),
      .addr_in(act_addr),
      .wdata(act_data),
      .done_q(cyc_done),
      .rdata_q(cyc_rdata),
      .ce_n_q(flash_ce_n),
      .oe_n_q(flash_oe_n),
      .we_n_q(flash_we_n),
      .addr_q(flash_addr),
      .dq_o_q(flash_dq_o),
      .dq_oe_q(flash_dq_oe),
      .dq_i(flash_dq_i)
   );
endmodule // flcs_host
`default_nettype wire

/* File: sim/flcs_host_checker.sv */
// concurrent checks on the pins and register port of the flash host controller
`timescale 1ns/10ps
`default_nettype none
module flcs_host_checker #(
   parameter AW = 18
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata_q,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_rp_n_q,
   input wire logic [AW-1:0] flash_addr,
   input wire logic flash_dq_oe
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
      else $error("read data outside its answer cycle");
   chk_write_drive: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
      else $error("write strobe without select or data drive");
   chk_read_release: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
      else $error("read strobe while driving data");
   chk_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
      else $error("write strobe width wrong");
   chk_oe_width: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*5] ##1 flash_oe_n)
      else $error("read strobe width wrong");
   chk_ce_setup: assert property ($fell(flash_ce_n) |->
      (flash_we_n && flash_oe_n) [*2] ##1 (!flash_we_n || !flash_oe_n))
      else $error("strobe setup after select wrong");
   chk_ce_release: assert property ($rose(flash_oe_n) || $rose(flash_we_n) |->
      !flash_ce_n [*2] ##1 flash_ce_n)
      else $error("select hold after strobe wrong");
   chk_addr_hold: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
      else $error("address moved inside a bus cycle");
   chk_rp_quiet: assert property (!flash_rp_n_q |-> flash_ce_n && flash_we_n)
      else $error("bus cycle during power-down");
   // main scenarios reached
   cover property ($fell(flash_we_n));
   cover property ($fell(flash_oe_n));
   cover property ($fell(flash_rp_n_q));
endmodule // flcs_host_checker
`default_nettype wire

/* File: sim/flcs_flash_model.sv */
// behavioural model of the flash command decoder and its write state machine
`timescale 1ns/10ps
`default_nettype none
module flcs_flash_model #(
   parameter [15:0] MFR_CODE = 16'h00a5, // arbitrary value
   parameter [15:0] DEV_CODE = 16'h5a3c // arbitrary value
) (
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic rp_n,
   input wire logic [17:0] addr,
   input wire logic [15:0] dq_o,
   input wire logic vpp_low,
   output wire logic [15:0] dq_i
);
   logic [15:0] mem [0:3]; // tiny array, address bits 1:0 only
   logic [7:0] sr = 8'h80, sr_lat = 8'h80; // status and its latched copy
   logic [1:0] mode = 2'd0; // 0 array, 1 identifier, 2 status
   logic [1:0] ad; // latched target word
   logic [15:0] pend_w, rd, last_rd = 16'h0;
   logic erasing = 0, susp_req = 0, prog_armed = 0, erase_armed = 0, ok;
   int left = 0; // ticks of 100 ns left in the running operation
   initial for (int i = 0; i < 4; i++) mem[i] = 16'hffff;
   // command writes take effect at the end of the write strobe
   always @(posedge we_n) if (!ce_n && rp_n) begin
      ok = sr[7] ? (!sr[6] || dq_o[7:0] inside {8'hff, 8'h70, 8'hd0})
                 : (dq_o[7:0] inside {8'h70, 8'hb0});
      if (prog_armed) begin
         prog_armed = 0;
         mode = 2'd2;
         if (vpp_low) sr[3] = 1;
         else begin
            ad = addr[1:0];
            pend_w = dq_o;
            sr[7] = 0;
            left = 10;
         end
      end else if (erase_armed) begin
         erase_armed = 0;
         mode = 2'd2;
         if (dq_o[7:0] != 8'hd0) sr[5:4] = 2'b11;
         else if (vpp_low || sr[3]) begin
            sr[5] = 1;
            sr[3] = 1;
         end else begin
            erasing = 1;
            sr[7] = 0;
            left = 40;
         end
      end else if (ok) case (dq_o[7:0])
         8'hff: mode = 2'd0;
         8'h90: mode = 2'd1;
         8'h70: mode = 2'd2;
         8'h50: sr[5:3] = 3'b000;
         8'h40, 8'h10: prog_armed = 1;
         8'h20: erase_armed = 1;
         8'hb0: if (erasing) susp_req = 1;
         8'hd0: if (sr[6]) sr[7:6] = 2'b00;
         default: ;
      endcase
   end
   // internal timer of the state machine, halted while suspended
   always #100 if (rp_n && left > 0 && !sr[6]) begin
      if (susp_req) begin
         susp_req = 0;
         sr[7:6] = 2'b11;
      end else begin
         left--;
         if (left == 0) begin
            sr[7] = 1;
            mode = 2'd2;
            if (erasing) for (int i = 0; i < 4; i++) mem[i] = 16'hffff;
            else mem[ad] = mem[ad] & pend_w;
            erasing = 0;
         end
      end
   end
   // power-down stops the running operation at once; program and erase setup stay armed
   always @(negedge rp_n) begin
      left = 0;
      erasing = 0;
      susp_req = 0;
      sr = 8'h80;
      mode = 2'd0;
   end
   // status is frozen at whichever strobe falls last
   always @(negedge ce_n or negedge oe_n) if (!ce_n && !oe_n) sr_lat = sr;
   always @(posedge oe_n) last_rd = rd;
   always_comb case (mode)
      2'd0: rd = mem[addr[1:0]];
      2'd1: rd = addr[0] ? DEV_CODE : MFR_CODE;
      default: rd = {8'h00, sr_lat};
   endcase
   // a released bus shows the inverse of the last value, not a stale copy
   assign dq_i = (!ce_n && !oe_n && rp_n) ? rd : ~last_rd;
endmodule // flcs_flash_model
`default_nettype wire

/* File: sim/tb_flash_command_status_control.sv */
// self-checking testbench of the flash host controller against the flash model
`timescale 1ns/10ps
`default_nettype none
module tb_flash_command_status_control;
   logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, vpp_low = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, rv;
   wire logic [31:0] reg_rdata_q;
   wire logic ce_n, oe_n, we_n, rp_n, byte_n, dq_oe;
   wire logic [17:0] addr;
   wire logic [15:0] dq_o, dq_i;
   int err_total = 0, num_checks = 0, cyc = 0;
   always #10 ref_clk = ~ref_clk;
   flcs_host #(.RP_CYC(2)) flcs_host_inst (.ref_clk(ref_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_rp_n_q(rp_n), .flash_byte_n_q(byte_n), .flash_addr(addr), .flash_dq_o(dq_o),
      .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
   flcs_flash_model flcs_flash_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .rp_n(rp_n), .addr(addr), .dq_o(dq_o), .vpp_low(vpp_low), .dq_i(dq_i));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge ref_clk);
      reg_wr <= 0;
   endtask
   // read data is taken in the one cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge ref_clk);
      reg_rd <= 0;
      @(negedge ref_clk);
      rv = reg_rdata_q;
   endtask
   // issue an order and poll until the controller is idle; rv holds the status word
   task automatic op(input logic [3:0] c);
      wr(8'h00, {28'h0, c});
      repeat (400) begin
         rd(8'h0c);
         if (rv[8] === 1'b0) break;
      end
      check("order ended", {31'h0, rv[8]}, 32'h0);
   endtask
   task automatic t_regs;
      check("idle data", reg_rdata_q, 32'h0);
      check("select idle", {31'h0, ce_n}, 32'h1);
      rd(8'h1c);
      check("unmapped", rv, 32'h0);
      wr(8'h04, 32'h0003ffff);
      rd(8'h04);
      check("addr reg", rv, 32'h0003ffff);
      wr(8'h18, 32'h1);
      rd(8'h18);
      check("byte cfg", rv, 32'h1);
      check("byte pin", {31'h0, byte_n}, 32'h0);
      wr(8'h18, 32'h0);
      rd(8'h18);
      check("word pin", {31'h0, byte_n}, 32'h1);
      $display("test regs done");
   endtask
   task automatic t_ident;
      op(4'h1);
      rd(8'h14);
      check("identifier", rv, 32'h5a3c00a5);
      $display("test ident done");
   endtask
   task automatic prog(input logic [15:0] d, input logic [15:0] exp);
      wr(8'h04, 32'h2);
      wr(8'h08, {16'h0, d});
      op(4'h4);
      check("program status", {24'h0, rv[7:0]}, 32'h80);
      op(4'h0);
      op(4'h8);
      rd(8'h10);
      check("program data", {16'h0, rv[15:0]}, {16'h0, exp});
   endtask
   task automatic t_program;
      prog(16'h5a0f, 16'h5a0f);
      prog(16'hf0f0, 16'h5000);
      $display("test program done");
   endtask
   task automatic t_erase;
      wr(8'h04, 32'h1);
      op(4'h5);
      check("erasing", {31'h0, rv[10]}, 32'h1);
      op(4'h6);
      check("suspend status", {24'h0, rv[7:0]}, 32'hc0);
      check("suspended", {31'h0, rv[11]}, 32'h1);
      op(4'h4);
      check("refused in suspend", {31'h0, rv[9]}, 32'h1);
      op(4'h7);
      op(4'h9);
      check("poll status", {24'h0, rv[7:0]}, 32'h80);
      repeat (100) begin
         op(4'h2);
         if (rv[7] === 1'b1) break;
      end
      check("erase done", {24'h0, rv[7:0]}, 32'h80);
      op(4'h0);
      op(4'h8);
      rd(8'h10);
      check("erased word", {16'h0, rv[15:0]}, 32'hffff);
      $display("test erase done");
   endtask
   task automatic t_supply;
      vpp_low <= 1;
      op(4'h5);
      op(4'h2);
      check("low supply", {24'h0, rv[7:0]}, 32'ha8);
      op(4'h5);
      check("erase refused", {31'h0, rv[9]}, 32'h1);
      vpp_low <= 0;
      op(4'h3);
      op(4'h2);
      check("cleared", {24'h0, rv[7:0]}, 32'h80);
      op(4'h7);
      check("resume refused", {31'h0, rv[9]}, 32'h1);
      op(4'ha);
      check("rp released", {31'h0, rp_n}, 32'h1);
      $display("test supply done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // cut a hang short
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      reset <= 0;
      @(posedge ref_clk);
      t_regs();
      t_ident();
      t_program();
      t_erase();
      t_supply();
      end_sim();
   end
endmodule // tb_flash_command_status_control
bind flcs_host flcs_host_checker #(.AW(AW)) flcs_host_checker_inst (.ref_clk(ref_clk),
   .reset(reset), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_rp_n_q(flash_rp_n_q),
   .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe));
`default_nettype wire
